// File: tam_pkg.sv
// Package with constants and carrier types of the transaction attribute modifier.
package tam_pkg;

   // ************************************************************
   // Field widths and positions
   // ************************************************************
   localparam int unsigned TAM_ADDR_W = 32;
   localparam int unsigned TAM_ID_W = 4;
   localparam int unsigned TAM_BEAT_W = 12;
   localparam int unsigned TAM_PIECE_W = 6;
   localparam int unsigned TAM_PAGE_BITS = 12;
   localparam int unsigned TAM_CACHE_BUF = 0;
   localparam int unsigned TAM_CACHE_MOD = 1;
   localparam int unsigned TAM_CACHE_RA = 2;
   localparam int unsigned TAM_CACHE_WA = 3;

   // ************************************************************
   // Sizes, limits and encodings
   // ************************************************************
   localparam logic [2:0] TAM_DN_SIZE = 3'h2;
   localparam logic [TAM_BEAT_W-1:0] TAM_MAX_PIECE = 12'h010;
   localparam logic [TAM_BEAT_W-1:0] TAM_PIECE_ROUND = 12'h00f;
   localparam int unsigned TAM_PIECE_SHIFT = 4;
   localparam logic [1:0] TAM_BURST_FIXED = 2'h0;
   localparam logic [1:0] TAM_BURST_INCR = 2'h1;
   localparam logic [1:0] TAM_BURST_WRAP = 2'h2;
   localparam logic [1:0] TAM_RESP_OKAY = 2'h0;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [TAM_ADDR_W-1:0] TAM_ADDR_RST = 32'h0000_0000;
   localparam logic [TAM_BEAT_W-1:0] TAM_BEAT_RST = 12'h000;
   localparam logic [TAM_PIECE_W-1:0] TAM_PIECE_RST = 6'h00;

   typedef enum logic [1:0] {
      TAM_ST_IDLE = 2'b00,
      TAM_ST_ISSUE = 2'b01,
      TAM_ST_WAIT = 2'b10
   } tam_state_e;

   typedef struct packed {
      logic write;
      logic [TAM_ID_W-1:0] id;
      logic [TAM_ADDR_W-1:0] addr;
      logic [3:0] region;
      logic [7:0] len;
      logic [2:0] size;
      logic [1:0] burst;
      logic lock;
      logic [3:0] cache;
      logic [2:0] prot;
      logic [3:0] qos;
   } tam_req_s;

   typedef struct packed {
      logic lookup;
      logic other_alloc;
      logic own_alloc;
   } tam_hint_s;

   typedef struct packed {
      logic write;
      logic last;
      logic [1:0] resp;
   } tam_rsp_s;

endpackage

// File: tam_modifier.sv
// Transaction attribute modifier: resizes, splits and re-attributes address requests.
`timescale 1ns/1ps

// Behaviour
// [R1] Cache attribute bit 1 high marks modifiable, low marks non-modifiable.
// [R2] Non-modifiable requests are never split or merged, except long bursts.
// [R3] Non-modifiable address, size, length, burst, lock and protection pass unchanged.
// [R4] Non-modifiable cache attribute may only lose its bufferable bit.
// [R5] Identifier and quality-of-service value may be rewritten on any request.
// [R6] Non-modifiable bursts above 16 beats split into pieces with adjusted addresses.
// [R7] Narrowing below requested beat size alters the request and pulses a flag.
// [R8] Modifiable requests may be split, merged or over-fetched.
// [R9] Wider modifiable writes rely on byte strobes to guard untouched bytes.
// [R10] Pieces of a modifiable request may take new address, size, length, burst.
// [R11] Lock and protection pass unchanged on every generated piece.
// [R12] Modifiable cache attribute is never altered, so visibility never drops.
// [R13] No generated piece leaves the 4KByte page of the original request.
// [R14] A single-copy-atomic beat is never split unless narrowing forces it.
// [R15] Same-identifier non-modifiable requests to one slave keep issue order.
// [R16] With unknown slave boundaries, same-identifier order is kept on the path.
// [R17] Ordering holds across bufferable and non-bufferable requests alike.
// [R18] Responses merged here are returned in the required order.
// [R19] Requesters needing read-write order wait for the earlier response first.
// [R20] Cache lookup is required when upper two attribute bits are nonzero.
// [R21] On reads the write-allocate bit means possibly cached by others.
// [R22] On writes the read-allocate bit means possibly cached by others.
module tam_modifier (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic up_valid,
   output logic up_ready,
   input wire tam_pkg::tam_req_s up_req,
   output logic dn_valid,
   input wire logic dn_ready,
   output tam_pkg::tam_req_s dn_req,
   output tam_pkg::tam_hint_s dn_hint,
   input wire logic rsp_valid,
   output logic rsp_ready,
   input wire tam_pkg::tam_rsp_s rsp_in,
   output logic up_rsp_valid,
   input wire logic up_rsp_ready,
   output tam_pkg::tam_rsp_s up_rsp,
   input wire logic cfg_clear_buf,
   input wire logic cfg_qos_en,
   input wire logic [3:0] cfg_qos,
   output logic alter_pulse
);
   import tam_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      tam_state_e st;
      tam_req_s cur;
      tam_hint_s hint;
      logic [TAM_BEAT_W-1:0] left;
      logic [TAM_PIECE_W-1:0] rsp_left;
      logic [1:0] worst;
      logic ofull;
      tam_rsp_s orsp;
      logic alter;
   } tam_core_s;

   tam_core_s core_q;
   tam_core_s core_d;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [2:0] tam_out_size(input logic [2:0] sz);
      tam_out_size = (sz > TAM_DN_SIZE) ? TAM_DN_SIZE : sz; // see [R7]
   endfunction

   // Total beats at the narrowed size; each wide beat becomes 2^(in-out) narrow beats.
   function automatic logic [TAM_BEAT_W-1:0] tam_total(input logic [7:0] len,
                                                       input logic [2:0] sz);
      logic [TAM_BEAT_W-1:0] beats;
      logic [2:0] sh;
      beats = {4'h0, len} + 12'h001;
      sh = sz - tam_out_size(sz);
      tam_total = beats << sh;
   endfunction

   // Only incrementing bursts are cut; other kinds go out as one piece.
   function automatic logic [TAM_BEAT_W-1:0] tam_piece(input logic [TAM_BEAT_W-1:0] left,
                                                       input logic [1:0] burst);
      if (burst == TAM_BURST_INCR && left > TAM_MAX_PIECE) begin
         tam_piece = TAM_MAX_PIECE; // see [R6]
      end else begin
         tam_piece = left;
      end
   endfunction

   function automatic logic [TAM_PIECE_W-1:0] tam_pieces(input logic [TAM_BEAT_W-1:0] total,
                                                         input logic [1:0] burst);
      logic [TAM_BEAT_W-1:0] p;
      p = (total + TAM_PIECE_ROUND) >> TAM_PIECE_SHIFT;
      if (burst == TAM_BURST_INCR) begin
         tam_pieces = p[TAM_PIECE_W-1:0];
      end else begin
         tam_pieces = 6'h01;
      end
   endfunction

   // Next piece starts on a beat boundary; only the in-page bits move, so the
   // upper address bits of the original request are kept.
   function automatic logic [TAM_ADDR_W-1:0] tam_next_addr(input logic [TAM_ADDR_W-1:0] a,
                                                           input logic [2:0] sz,
                                                           input logic [TAM_BEAT_W-1:0] n);
      logic [TAM_PAGE_BITS-1:0] lo;
      lo = a[TAM_PAGE_BITS-1:0] >> sz;
      lo = lo + n;
      lo = lo << sz;
      tam_next_addr = {a[TAM_ADDR_W-1:TAM_PAGE_BITS], lo}; // see [R13]
   endfunction

   function automatic logic [1:0] tam_max_resp(input logic [1:0] a, input logic [1:0] b);
      tam_max_resp = (a > b) ? a : b;
   endfunction

   // ************************************************************
   // Request attribute policy
   // ************************************************************
   tam_req_s first_req;
   tam_hint_s first_hint;
   logic [TAM_BEAT_W-1:0] first_total;
   logic [TAM_BEAT_W-1:0] first_piece;
   logic up_mod;
   logic narrowed;

   always_comb begin
      up_mod = up_req.cache[TAM_CACHE_MOD]; // see [R1]
      narrowed = (tam_out_size(up_req.size) != up_req.size);
      first_total = tam_total(up_req.len, up_req.size);
      first_req = up_req; // see [R3] [R11]
      if (narrowed) begin
         // Narrowing keeps the address, so the first narrow beat still lands on
         // the requested byte; later pieces restart beat aligned.
         first_req.size = tam_out_size(up_req.size); // see [R7] [R14]
         first_req.burst = TAM_BURST_INCR;
      end
      first_piece = tam_piece(first_total, first_req.burst);
      first_req.len = 8'(first_piece - 12'h001);
      if (!up_mod && cfg_clear_buf) begin
         first_req.cache[TAM_CACHE_BUF] = 1'b0; // see [R4]
      end
      // Modifiable attributes are left alone: rewriting them cheaply risks
      // hiding a write or skipping a lookup, and must agree per address range.
      first_req.cache[TAM_CACHE_WA:TAM_CACHE_MOD] = up_req.cache[TAM_CACHE_WA:TAM_CACHE_MOD]; // see [R12]
      if (cfg_qos_en) begin
         first_req.qos = cfg_qos; // see [R5]
      end
      first_hint.lookup = |up_req.cache[TAM_CACHE_WA:TAM_CACHE_RA]; // see [R20]
      if (up_req.write) begin
         first_hint.other_alloc = up_req.cache[TAM_CACHE_RA]; // see [R22]
         first_hint.own_alloc = up_req.cache[TAM_CACHE_WA];
      end else begin
         first_hint.other_alloc = up_req.cache[TAM_CACHE_WA]; // see [R21]
         first_hint.own_alloc = up_req.cache[TAM_CACHE_RA];
      end
   end

   // ************************************************************
   // Response merge
   // ************************************************************
   logic rsp_take;
   logic rsp_final;
   logic rsp_fwd;
   logic [TAM_BEAT_W-1:0] cur_piece;
   logic [TAM_BEAT_W-1:0] rest;

   always_comb begin
      rsp_ready = (core_q.st != TAM_ST_IDLE) && (!core_q.ofull || up_rsp_ready);
      rsp_take = rsp_valid && rsp_ready;
      // Every piece returns one write answer or one read last beat.
      rsp_final = (core_q.rsp_left == 6'h01) && (rsp_in.write || rsp_in.last);
      // Write answers of early pieces are absorbed; one merged answer goes up.
      rsp_fwd = !rsp_in.write || rsp_final; // see [R18]
      cur_piece = {4'h0, core_q.cur.len} + 12'h001;
      rest = core_q.left - cur_piece;
   end

   // ************************************************************
   // Sequencer
   // ************************************************************
   always_comb begin
      core_d = core_q;
      core_d.alter = 1'b0;
      if (core_q.ofull && up_rsp_ready) begin
         core_d.ofull = 1'b0;
      end
      case (core_q.st)
         TAM_ST_IDLE: begin
            // One request at a time; the next is taken only after every
            // answer of the last has come back. This costs throughput but
            // keeps same-identifier order for any slave map.
            if (up_valid) begin // see [R15] [R16] [R17]
               core_d.st = TAM_ST_ISSUE;
               core_d.cur = first_req;
               core_d.hint = first_hint;
               core_d.left = first_total;
               core_d.rsp_left = tam_pieces(first_total, first_req.burst); // see [R2]
               core_d.worst = TAM_RESP_OKAY;
               core_d.alter = narrowed; // see [R7]
            end
         end
         TAM_ST_ISSUE: begin
            if (dn_ready) begin
               core_d.left = rest;
               if (rest == TAM_BEAT_RST) begin
                  core_d.st = TAM_ST_WAIT;
               end else begin
                  // Only length and start address differ between pieces.
                  core_d.cur.addr = tam_next_addr(core_q.cur.addr, core_q.cur.size,
                                                  cur_piece); // see [R6] [R10]
                  core_d.cur.len = 8'(tam_piece(rest, core_q.cur.burst) - 12'h001);
               end
            end
         end
         TAM_ST_WAIT: begin
            core_d.st = TAM_ST_WAIT;
         end
         default: begin
            core_d.st = TAM_ST_IDLE;
         end
      endcase
      if (rsp_take) begin
         if (rsp_in.write) begin
            core_d.worst = tam_max_resp(core_q.worst, rsp_in.resp);
         end
         if (rsp_in.write || rsp_in.last) begin
            core_d.rsp_left = core_q.rsp_left - 6'h01;
         end
         if (rsp_fwd) begin
            core_d.ofull = 1'b1;
            core_d.orsp.write = rsp_in.write;
            core_d.orsp.last = rsp_final || rsp_in.write;
            core_d.orsp.resp = rsp_in.write ? tam_max_resp(core_q.worst, rsp_in.resp)
                                            : rsp_in.resp;
         end
         if (rsp_final) begin
            core_d.st = TAM_ST_IDLE;
            core_d.worst = TAM_RESP_OKAY;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         core_q.st <= TAM_ST_IDLE;
         core_q.cur <= '0;
         core_q.hint <= '0;
         core_q.left <= TAM_BEAT_RST;
         core_q.rsp_left <= TAM_PIECE_RST;
         core_q.worst <= TAM_RESP_OKAY;
         core_q.ofull <= 1'b0;
         core_q.orsp <= '0;
         core_q.alter <= 1'b0;
      end else begin
         core_q <= core_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Modifiable writes are never widened here, so byte strobes pass untouched.
   assign up_ready = (core_q.st == TAM_ST_IDLE); // see [R8] [R9]
   assign dn_valid = (core_q.st == TAM_ST_ISSUE);
   assign dn_req = core_q.cur;
   assign dn_hint = core_q.hint;
   assign up_rsp_valid = core_q.ofull;
   assign up_rsp = core_q.orsp;
   assign alter_pulse = core_q.alter;

endmodule

// File: tam_modifier_sva.sv
// Checker of the transaction attribute modifier port behaviour.
`timescale 1ns/1ps
module tam_modifier_sva (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic up_valid,
   input wire logic up_ready,
   input wire tam_pkg::tam_req_s up_req,
   input wire logic dn_valid,
   input wire logic dn_ready,
   input wire tam_pkg::tam_req_s dn_req,
   input wire tam_pkg::tam_hint_s dn_hint,
   input wire logic cfg_clear_buf,
   input wire logic cfg_qos_en,
   input wire logic [3:0] cfg_qos,
   input wire logic alter_pulse
);
   import tam_pkg::*;
   // ****
   // Request seen at the take
   // ****
   tam_req_s req_q;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         req_q <= '0;
      end else if (up_valid && up_ready) begin
         req_q <= up_req;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence s_take;
      up_valid && up_ready;
   endsequence
   sequence s_issue;
      dn_valid && !up_ready;
   endsequence
   a_take_issue: assert property (s_take |=> s_issue)
      else $error("take not followed by issue");
   a_piece_hold: assert property (dn_valid && !dn_ready |=> dn_valid && $stable(dn_req))
      else $error("piece changed before accept");
   a_lock_prot: assert property (dn_valid |-> dn_req.lock == req_q.lock &&
      dn_req.prot == req_q.prot && dn_req.id == req_q.id) else $error("lock or prot altered");
   a_nonmod_same: assert property (dn_valid && !req_q.cache[1] && req_q.size <= TAM_DN_SIZE &&
      req_q.len < 8'h10 |-> dn_req.addr == req_q.addr && dn_req.len == req_q.len &&
      dn_req.size == req_q.size && dn_req.burst == req_q.burst)
      else $error("fixed request altered");
   a_cache_attr: assert property (dn_valid |-> dn_req.cache[3:1] == req_q.cache[3:1] &&
      dn_req.cache[0] == (req_q.cache[0] && (req_q.cache[1] || !cfg_clear_buf)))
      else $error("cache attribute altered");
   a_page_kept: assert property (dn_valid |->
      dn_req.addr[TAM_ADDR_W-1:TAM_PAGE_BITS] == req_q.addr[TAM_ADDR_W-1:TAM_PAGE_BITS])
      else $error("piece left page");
   a_piece_len: assert property (dn_valid && req_q.burst == TAM_BURST_INCR |-> dn_req.len <= 8'h0f)
      else $error("piece too long");
   a_narrow_flag: assert property (s_take ##0 up_req.size > TAM_DN_SIZE |=> alter_pulse &&
      dn_req.size == TAM_DN_SIZE) else $error("narrowing not flagged");
   a_hint_map: assert property (dn_valid |-> dn_hint.lookup == (|req_q.cache[3:2]) &&
      dn_hint.other_alloc == (req_q.write ? req_q.cache[2] : req_q.cache[3]))
      else $error("hint wrong");
   a_qos_set: assert property (dn_valid |-> dn_req.qos == (cfg_qos_en ? cfg_qos : req_q.qos))
      else $error("qos wrong");
endmodule

// File: tam_slave_model.sv
// Downstream slave model answering pieces of the transaction attribute modifier.
`timescale 1ns/1ps
module tam_slave_model (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic slow,
   input wire logic err,
   input wire logic dn_valid,
   output logic dn_ready,
   input wire tam_pkg::tam_req_s dn_req,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output tam_pkg::tam_rsp_s rsp_in
);
   import tam_pkg::*;
   tam_rsp_s q[$];
   int i;
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         q.delete();
         dn_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_in <= '0;
      end else begin
         if (rsp_valid && rsp_ready) begin
            void'(q.pop_front());
         end
         if (dn_valid && dn_ready) begin
            // A write piece earns one answer; a short write piece errs when asked to.
            for (i = 0; i <= (dn_req.write ? 0 : int'(dn_req.len)); i++) begin
               q.push_back({dn_req.write, dn_req.write || i == int'(dn_req.len),
                  (err && dn_req.write && dn_req.len != 8'h0f) ? 2'h2 : TAM_RESP_OKAY});
            end
         end
         rsp_valid <= q.size() > 0;
         // Idle lines flip so a stale answer never looks valid.
         rsp_in <= (q.size() > 0) ? q[0] : ~rsp_in;
         dn_ready <= slow ? ~dn_ready : 1'b1;
      end
   end
endmodule

// File: tam_modifier_tb.sv
// Self-checking testbench of the transaction attribute modifier.
`timescale 1ns/1ps
module tam_modifier_tb;
   import tam_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic up_valid = 1'b0;
   logic up_rsp_ready = 1'b1;
   logic cfg_clear_buf = 1'b1;
   logic cfg_qos_en = 1'b0;
   logic [3:0] cfg_qos = 4'h0;
   logic slow = 1'b0;
   logic err = 1'b0;
   logic up_ready, dn_valid, dn_ready, rsp_valid, rsp_ready, up_rsp_valid, alter_pulse;
   tam_req_s up_req = '0;
   tam_req_s dn_req, exp;
   tam_hint_s dn_hint;
   tam_rsp_s rsp_in, up_rsp;
   tam_req_s pcs[$];
   tam_rsp_s rs[$];
   int n_errors = 0;
   int tests_run = 0;
   int n_alt = 0;
   always #20 clk_sys = ~clk_sys;
   tam_modifier dut_u (.clk_sys, .sys_rst, .up_valid, .up_ready, .up_req, .dn_valid, .dn_ready,
      .dn_req, .dn_hint, .rsp_valid, .rsp_ready, .rsp_in, .up_rsp_valid, .up_rsp_ready, .up_rsp,
      .cfg_clear_buf, .cfg_qos_en, .cfg_qos, .alter_pulse);
   tam_slave_model slv_u (.clk_sys, .sys_rst, .slow, .err, .dn_valid, .dn_ready, .dn_req,
      .rsp_valid, .rsp_ready, .rsp_in);
   always @(posedge clk_sys) begin
      if (dn_valid && dn_ready) pcs.push_back(dn_req);
      if (up_rsp_valid && up_rsp_ready) rs.push_back(up_rsp);
      if (alter_pulse) n_alt++;
   end
   always @(negedge clk_sys) begin
      up_rsp_ready = slow ? ~up_rsp_ready : 1'b1;
   end
   // ****
   // Shared tasks
   // ****
   task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] want);
      tests_run++;
      if (seen !== want) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", name, want, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d, errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   function automatic tam_req_s mk(logic w, logic [31:0] a, logic [7:0] l, logic [2:0] s,
      logic [3:0] c);
      mk = '{w, 4'h5, a, 4'h3, l, s, TAM_BURST_INCR, 1'b1, c, 3'h5, 4'h9};
   endfunction
   task automatic run(input tam_req_s r);
      int k;
      pcs.delete();
      rs.delete();
      n_alt = 0;
      @(negedge clk_sys);
      up_req = r;
      up_valid = 1'b1;
      @(negedge clk_sys);
      up_valid = 1'b0;
      for (k = 0; k < 400 && !(up_ready && !up_rsp_valid); k++) @(negedge clk_sys);
      if (k == 400) begin
         n_errors++;
         finish_test();
      end
   endtask
   // ****
   // Scenarios
   // ****
   task automatic sc_nonmod_keep();
      exp = mk(1'b1, 32'h1234_5f00, 8'h03, 3'h2, 4'h5);
      run(exp);
      exp.cache = 4'h4;
      chk("piece count", pcs.size(), 1);
      chk("piece", pcs[0], exp);
      chk("answer", {rs.size(), rs[0]}, {32'd1, 4'hc});
   endtask
   task automatic sc_long_read();
      slow = 1'b1;
      cfg_qos_en = 1'b1;
      cfg_qos = 4'ha;
      run(mk(1'b0, 32'h0000_0100, 8'd39, 3'h2, 4'h8));
      chk("piece count", pcs.size(), 3);
      for (int k = 0; k < 3; k++) begin
         exp = mk(1'b0, 32'h0000_0100 + 32'(k * 64), (k < 2) ? 8'h0f : 8'h07, 3'h2, 4'h8);
         exp.qos = 4'ha;
         chk("split piece", pcs[k], exp);
      end
      chk("beats", rs.size(), 40);
      for (int k = 0; k < 40; k++) chk("beat last", rs[k].last, k == 39);
      slow = 1'b0;
      cfg_qos_en = 1'b0;
   endtask
   task automatic sc_narrow();
      exp = mk(1'b1, 32'h2000_0ff0, 8'h01, 3'h3, 4'h7);
      run(exp);
      exp.size = 3'h2;
      exp.len = 8'h03;
      chk("narrow piece", pcs[0], exp);
      chk("alter flag", n_alt, 1);
   endtask
   task automatic sc_split_err();
      cfg_clear_buf = 1'b0;
      err = 1'b1;
      run(mk(1'b1, 32'h0000_3000, 8'd19, 3'h2, 4'h1));
      chk("second piece", {pcs[1].addr, pcs[1].len, pcs[1].cache}, {32'h3040, 8'h03, 4'h1});
      chk("merged answer", {rs.size(), rs[0]}, {32'd1, 4'he});
      err = 1'b0;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      sys_rst = 1'b0;
      sc_nonmod_keep();
      sc_long_read();
      sc_narrow();
      sc_split_err();
      finish_test();
   end
endmodule
bind tam_modifier tam_modifier_sva chk_u (.clk_sys, .sys_rst, .up_valid, .up_ready, .up_req,
   .dn_valid, .dn_ready, .dn_req, .dn_hint, .cfg_clear_buf, .cfg_qos_en, .cfg_qos, .alter_pulse);
